// ---- hdl/softstart_pwm_pkg.sv ----
// Constants, timing and input indices for the soft-start PWM core
// How it works
// - Soft start begins from zero at supply good
// - Soft-start level rises in 32 equal steps
// - One soft-start step every 600 us
// - Soft start ends at 20 ms, sink off
// - Switching clock 100 kHz, +-4% over 4 ms
// - Gate duty never exceeds 0.75 of period
// - Frequency jitter only after soft start ends
// - Clock sets latch; regulation, soft-start and current-sense comparators reset it
// - Latch reset forces gate off at once
// - Gate held low while supply below threshold
// - Current limit ends each pulse cycle by cycle
// - 220 ns leading-edge blanking after gate turn-on
// - Burst mode enables reduced 0.31 V current limit
// - Short winding filtered 190 ns before latching off
// - Burst and restart entry need 20 ms blanking
// - Blanking end releases clamp; wait extension level
// - Extra 8 us blanking before auto restart
// - Overload blanking disabled during soft start
// - Burst uses basic blanking; restart adds extension
// - Startup cell control off while in burst
// - Supply off clears bias and soft-start counter
// - Feedback low must persist 20 ms for burst
// - Overload timer starts on feedback above 4.5 V
package softstart_pwm_pkg;

  localparam int MCLK_KHZ          = 125000;
  localparam int MCLK_MHZ          = 125;

  localparam int SS_STEP_TIME_US   = 600;
  localparam int SS_END_TIME_MS    = 20;
  localparam int SS_STEPS          = 32;
  localparam int SS_LVL_W          = 6;
  localparam int SS_STEP_CYC_DEF   = SS_STEP_TIME_US * MCLK_MHZ;
  localparam int SS_END_CYC_DEF    = SS_END_TIME_MS * MCLK_KHZ;

  localparam int SW_FREQ_KHZ       = 100;
  localparam int SW_PERIOD_CYC     = MCLK_KHZ / SW_FREQ_KHZ;
  localparam int JIT_PCT           = 4;
  localparam int JIT_DEV_CYC       = SW_PERIOD_CYC * JIT_PCT / 100;
  localparam int JIT_PERIOD_MS     = 4;
  localparam int JIT_STEP_CYC_DEF  =
    JIT_PERIOD_MS * MCLK_KHZ / (4 * JIT_DEV_CYC);
  localparam int PER_W             = 12;
  localparam int JIT_W             = 8;

  // Duty ceiling 0.75 = 3 / 4
  localparam int DUTY_NUM          = 3;
  localparam int DUTY_SHIFT        = 2;

  localparam int LEB_TIME_NS       = 220;
  localparam int LEB_CYC           = (LEB_TIME_NS * MCLK_MHZ + 999) / 1000;
  localparam int LEB_W             = 6;
  localparam int SW_TIME_NS        = 190;
  localparam int SW_CYC            = (SW_TIME_NS * MCLK_MHZ + 999) / 1000;
  localparam int RESTART_TIME_NS   = 8000;
  localparam int RESTART_CYC       =
    (RESTART_TIME_NS * MCLK_MHZ + 999) / 1000;
  localparam int BLANK_TIME_MS     = 20;
  localparam int BLANK_CYC_DEF     = BLANK_TIME_MS * MCLK_KHZ;

  // Comparator input indices
  localparam int CMP_SUPPLY        = 0;
  localparam int CMP_REGULATION    = 1;
  localparam int CMP_SOFTSTART     = 2;
  localparam int CMP_CURRENT_LIMIT = 3;
  localparam int CMP_BURST_CURRENT = 4;
  localparam int CMP_SHORT_WINDING = 5;
  localparam int CMP_FB_LOW        = 6;
  localparam int CMP_FB_HIGH       = 7;
  localparam int CMP_EXT_LEVEL     = 8;
  localparam int CMP_COUNT         = 9;

endpackage

// ---- hdl/persist_if.sv ----
// Run request and done flag of one persistence timer
`timescale 1ns/10ps
interface persist_if;
  logic run;
  logic done;
  modport owner (output run, input done);
  modport timer (input run, output done);
endinterface

// ---- hdl/persist_timer.sv ----
// Timer that reports done once its run level has held for CYCLES cycles
`timescale 1ns/10ps
module persist_timer #(
  parameter int CYCLES = 4
) (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_reset_n,
  input  wire logic i_ce,
  // Run level and result
  persist_if.timer  p
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] cnt_reg;
  logic          done_reg;

  if (CYCLES < 2) begin : g_bad_cycles
    $error("persist_timer needs CYCLES of at least 2");
  end

  // Any drop of run restarts the count from zero
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end else if (i_ce) begin
      if (!p.run) begin
        cnt_reg  <= '0;
        done_reg <= 1'b0;
      end else if (cnt_reg == CW'(CYCLES - 1)) begin
        done_reg <= 1'b1;
      end else begin
        cnt_reg  <= cnt_reg + CW'(1);
      end
    end
  end

  assign p.done = done_reg;

  timer_drop_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    (i_ce && !p.run) |=> !done_reg)
    else $error("timer done held after run dropped");

endmodule

// ---- hdl/softstart_pwm_blanking_control.sv ----
// Soft start, jittered PWM, blanking and fault mode control core
`timescale 1ns/10ps
module softstart_pwm_blanking_control
  import softstart_pwm_pkg::*;
#(
  parameter int SS_STEP_CYCLES  = SS_STEP_CYC_DEF,
  parameter int SS_END_CYCLES   = SS_END_CYC_DEF,
  parameter int BLANK_CYCLES    = BLANK_CYC_DEF,
  parameter int JIT_STEP_CYCLES = JIT_STEP_CYC_DEF
) (
  // Clock, reset and enable
  input  wire logic                i_mclk,
  input  wire logic                i_reset_n,
  input  wire logic                i_ce,
  // Analog front-end decisions
  input  wire logic                i_supply_good,
  input  wire logic                i_regulation_cmp,
  input  wire logic                i_softstart_cmp,
  input  wire logic                i_current_limit_cmp,
  input  wire logic                i_burst_current_cmp,
  input  wire logic                i_short_winding_cmp,
  input  wire logic                i_feedback_low_cmp,
  input  wire logic                i_feedback_high_cmp,
  input  wire logic                i_extension_level_cmp,
  // Gate drive
  output logic                     o_gate,
  // Soft start
  output logic [SS_LVL_W-1:0]      o_softstart_level,
  output logic                     o_softstart_sink_en,
  // Modes and switches
  output logic                     o_burst_mode,
  output logic                     o_clamp_release,
  output logic                     o_auto_restart,
  output logic                     o_latched_off,
  output logic                     o_startup_cell_en
);

  localparam int SS_W  = $clog2(SS_END_CYCLES + 1);
  localparam int JT_W  = $clog2(JIT_STEP_CYCLES + 1);

  if (SS_STEP_CYCLES < 1 || JIT_STEP_CYCLES < 1 ||
      SS_STEP_CYCLES * SS_STEPS > SS_END_CYCLES) begin : g_bad_params
    $error("soft-start steps must fit inside the soft-start period");
  end

  function automatic logic at_last(input logic [31:0] cnt,
                                   input int          cycles);
    at_last = (cnt == 32'(cycles - 1));
  endfunction

  // Input synchronisers
  logic [CMP_COUNT-1:0] cmp_raw;
  logic [CMP_COUNT-1:0] cmp_sync;

  assign cmp_raw[CMP_SUPPLY]        = i_supply_good;
  assign cmp_raw[CMP_REGULATION]    = i_regulation_cmp;
  assign cmp_raw[CMP_SOFTSTART]     = i_softstart_cmp;
  assign cmp_raw[CMP_CURRENT_LIMIT] = i_current_limit_cmp;
  assign cmp_raw[CMP_BURST_CURRENT] = i_burst_current_cmp;
  assign cmp_raw[CMP_SHORT_WINDING] = i_short_winding_cmp;
  assign cmp_raw[CMP_FB_LOW]        = i_feedback_low_cmp;
  assign cmp_raw[CMP_FB_HIGH]       = i_feedback_high_cmp;
  assign cmp_raw[CMP_EXT_LEVEL]     = i_extension_level_cmp;

  for (genvar g = 0; g < CMP_COUNT; g++) begin : g_sync
    logic meta_reg;
    logic sync_reg;
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
      end else if (i_ce) begin
        meta_reg <= cmp_raw[g];
        sync_reg <= meta_reg;
      end
    end
    assign cmp_sync[g] = sync_reg;
  end

  logic supply_ok;
  logic reg_cmp;
  logic ss_cmp;
  logic cl_cmp;
  logic bc_cmp;
  logic sw_cmp;
  logic fb_low;
  logic fb_high;
  logic ext_level;

  assign supply_ok = cmp_sync[CMP_SUPPLY];
  assign reg_cmp   = cmp_sync[CMP_REGULATION];
  assign ss_cmp    = cmp_sync[CMP_SOFTSTART];
  assign cl_cmp    = cmp_sync[CMP_CURRENT_LIMIT];
  assign bc_cmp    = cmp_sync[CMP_BURST_CURRENT];
  assign sw_cmp    = cmp_sync[CMP_SHORT_WINDING];
  assign fb_low    = cmp_sync[CMP_FB_LOW];
  assign fb_high   = cmp_sync[CMP_FB_HIGH];
  assign ext_level = cmp_sync[CMP_EXT_LEVEL];

  // Soft start
  logic [SS_W-1:0]     ss_time_reg;
  logic [SS_W-1:0]     ss_tick_reg;
  logic [SS_LVL_W-1:0] ss_level_reg;
  logic                ss_done_reg;
  logic                ss_active_reg;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ss_time_reg   <= '0;
      ss_tick_reg   <= '0;
      ss_level_reg  <= '0;
      ss_done_reg   <= 1'b0;
      ss_active_reg <= 1'b0;
    end else if (i_ce) begin
      if (!supply_ok) begin
        ss_time_reg   <= '0;
        ss_tick_reg   <= '0;
        ss_level_reg  <= '0;
        ss_done_reg   <= 1'b0;
        ss_active_reg <= 1'b0;
      end else if (!ss_done_reg) begin
        ss_active_reg <= 1'b1;
        if (at_last(32'(ss_time_reg), SS_END_CYCLES)) begin
          ss_done_reg   <= 1'b1;
          ss_active_reg <= 1'b0;
        end else begin
          ss_time_reg <= ss_time_reg + SS_W'(1);
        end
        if (at_last(32'(ss_tick_reg), SS_STEP_CYCLES)) begin
          ss_tick_reg <= '0;
          if (ss_level_reg != SS_LVL_W'(SS_STEPS)) begin
            ss_level_reg <= ss_level_reg + SS_LVL_W'(1);
          end
        end else begin
          ss_tick_reg <= ss_tick_reg + SS_W'(1);
        end
      end
    end
  end

  // Triangular frequency sweep, parked at centre during soft start
  logic [JT_W-1:0]  jit_tick_reg;
  logic [JIT_W-1:0] jit_off_reg;
  logic             jit_up_reg;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      jit_tick_reg <= '0;
      jit_off_reg  <= JIT_W'(JIT_DEV_CYC);
      jit_up_reg   <= 1'b1;
    end else if (i_ce) begin
      if (!ss_done_reg || !supply_ok) begin
        jit_tick_reg <= '0;
        jit_off_reg  <= JIT_W'(JIT_DEV_CYC);
        jit_up_reg   <= 1'b1;
      end else if (at_last(32'(jit_tick_reg), JIT_STEP_CYCLES)) begin
        jit_tick_reg <= '0;
        if (jit_up_reg) begin
          jit_off_reg <= jit_off_reg + JIT_W'(1);
          if (jit_off_reg == JIT_W'(2 * JIT_DEV_CYC - 1)) begin
            jit_up_reg <= 1'b0;
          end
        end else begin
          jit_off_reg <= jit_off_reg - JIT_W'(1);
          if (jit_off_reg == JIT_W'(1)) begin
            jit_up_reg <= 1'b1;
          end
        end
      end else begin
        jit_tick_reg <= jit_tick_reg + JT_W'(1);
      end
    end
  end

  // Period is frozen per cycle so jitter cannot lift the duty cap
  logic [PER_W-1:0]   period;
  logic [PER_W-1:0]   cyc_period_reg;
  logic [PER_W+1:0]   duty_prod;
  logic [PER_W-1:0]   on_limit;
  logic [PER_W-1:0]   phase_reg;
  logic               set_pulse;

  assign period    = PER_W'(SW_PERIOD_CYC - JIT_DEV_CYC) +
                     PER_W'(jit_off_reg);
  assign duty_prod = {2'h0, cyc_period_reg} * (PER_W+2)'(DUTY_NUM);
  assign on_limit  = duty_prod[DUTY_SHIFT +: PER_W];
  assign set_pulse = (phase_reg == '0);

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase_reg      <= '0;
      cyc_period_reg <= PER_W'(SW_PERIOD_CYC);
    end else if (i_ce) begin
      if (set_pulse) begin
        cyc_period_reg <= period;
      end
      if (!supply_ok || phase_reg >= cyc_period_reg - PER_W'(1)) begin
        phase_reg <= '0;
      end else begin
        phase_reg <= phase_reg + PER_W'(1);
      end
    end
  end

  // PWM latch with leading-edge blanking
  logic             pwm_latch_reg;
  logic [LEB_W-1:0] leb_reg;
  logic             burst_mode_reg;
  logic             latched_off_reg;
  logic             auto_restart_reg;
  logic             blank_active;
  logic             term_blankable;
  logic             hard_off;
  logic             latch_reset;

  assign blank_active   = set_pulse || (leb_reg != '0);
  assign term_blankable = !blank_active &&
                          (reg_cmp || cl_cmp ||
                           (burst_mode_reg && bc_cmp));
  assign hard_off       = !supply_ok || latched_off_reg ||
                          auto_restart_reg || (phase_reg >= on_limit);
  assign latch_reset    = hard_off || ss_cmp || term_blankable;

  // Reset dominates set so a stuck comparator can never hold the gate on
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pwm_latch_reg <= 1'b0;
    end else if (i_ce) begin
      if (latch_reset) begin
        pwm_latch_reg <= 1'b0;
      end else if (set_pulse) begin
        pwm_latch_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      leb_reg <= '0;
    end else if (i_ce) begin
      if (set_pulse) begin
        leb_reg <= LEB_W'(LEB_CYC);
      end else if (leb_reg != '0) begin
        leb_reg <= leb_reg - LEB_W'(1);
      end
    end
  end

  // Blanking and spike filter timers
  persist_if sw_p ();
  persist_if burst_p ();
  persist_if ovl_p ();
  persist_if rst_p ();

  logic clamp_release_reg;
  logic startup_cell_reg;
  assign sw_p.run    = sw_cmp;
  assign burst_p.run = fb_low && ss_done_reg && !burst_mode_reg;
  assign ovl_p.run   = fb_high && ss_done_reg;
  assign rst_p.run   = clamp_release_reg && ext_level;
  persist_timer #(.CYCLES(SW_CYC)) u_sw_filter (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .p         (sw_p)
  );
  // Burst entry sees the basic interval only
  persist_timer #(.CYCLES(BLANK_CYCLES)) u_burst_blank (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .p         (burst_p)
  );
  persist_timer #(.CYCLES(BLANK_CYCLES)) u_ovl_blank (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .p         (ovl_p)
  );
  persist_timer #(.CYCLES(RESTART_CYC)) u_restart_filter (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .p         (rst_p)
  );
  // Mode flags; a set in the same cycle as supply loss still lands
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      burst_mode_reg    <= 1'b0;
      clamp_release_reg <= 1'b0;
      auto_restart_reg  <= 1'b0;
      latched_off_reg   <= 1'b0;
      startup_cell_reg  <= 1'b0;
    end else if (i_ce) begin
      clamp_release_reg <= ovl_p.done;
      startup_cell_reg  <= !supply_ok && !burst_mode_reg;
      if (burst_p.done) begin
        burst_mode_reg <= 1'b1;
      end else if (fb_high || !supply_ok) begin
        burst_mode_reg <= 1'b0;
      end
      if (rst_p.done) begin
        auto_restart_reg <= 1'b1;
      end else if (!supply_ok) begin
        auto_restart_reg <= 1'b0;
      end
      if (sw_p.done) begin
        latched_off_reg <= 1'b1;
      end else if (!supply_ok) begin
        latched_off_reg <= 1'b0;
      end
    end
  end

  assign o_gate              = pwm_latch_reg;
  assign o_softstart_level   = ss_level_reg;
  assign o_softstart_sink_en = ss_active_reg;
  assign o_burst_mode        = burst_mode_reg;
  assign o_clamp_release     = clamp_release_reg;
  assign o_auto_restart      = auto_restart_reg;
  assign o_latched_off       = latched_off_reg;
  assign o_startup_cell_en   = startup_cell_reg;
  // Checks
  sequence gate_on_s;
    i_ce && pwm_latch_reg;
  endsequence
  sequence sw_accept_s;
    i_ce && sw_p.done;
  endsequence
  uvlo_gate_low_a: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n) (i_ce && !supply_ok) |=> !pwm_latch_reg)
    else $error("gate on while supply below threshold");
  current_cut_a: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    (gate_on_s and (!blank_active && cl_cmp)) |=> !pwm_latch_reg)
    else $error("current limit did not end pulse");
  edge_blank_a: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    (gate_on_s and (leb_reg != '0 && !hard_off && !ss_cmp))
      |=> pwm_latch_reg)
    else $error("gate cut during edge blanking");
  duty_cap_a: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    $rose(pwm_latch_reg) |-> phase_reg == PER_W'(1) && on_limit < period)
    else $error("gate rose off the clock pulse");
  softstart_end_a: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    $rose(ss_done_reg) |-> ss_level_reg == SS_LVL_W'(SS_STEPS) &&
      !ss_active_reg)
    else $error("soft start ended below final level");
  jitter_fixed_a: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    !ss_done_reg |-> period == PER_W'(SW_PERIOD_CYC))
    else $error("frequency moved during soft start");
  burst_cell_off_a: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n) (i_ce && burst_mode_reg) |=> !startup_cell_reg)
    else $error("startup cell enabled in burst mode");
  latch_entry_a: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n) sw_accept_s |=> latched_off_reg ##1
      (!pwm_latch_reg || !$past(i_ce)))
    else $error("short winding did not latch off");
  restart_needs_clamp_a: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n)
    $rose(auto_restart_reg) |-> $past(clamp_release_reg, 2) &&
      $past(ext_level, 2))
    else $error("auto restart without clamp release");
  ovl_soft_block_a: assert property (@(posedge i_mclk)
    disable iff (!i_reset_n) !ss_done_reg |-> !ovl_p.run && !burst_p.run)
    else $error("overload blanking ran during soft start");
endmodule

// ---- test/comparator_model.sv ----
// Behavioural current-sense and feedback comparators driven by gate on-time
`timescale 1ns/10ps
module comparator_model (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  // Gate from the controller, trip setup from the bench
  input  wire logic        i_gate,
  input  wire logic [1:0]  i_sel,
  input  wire logic [11:0] i_trip_at,
  input  wire logic [5:0]  i_spike_len,
  // Comparator decisions
  output logic             o_current_limit,
  output logic             o_regulation,
  output logic             o_softstart,
  output logic             o_burst_current
);
  logic [11:0] on_count_reg;
  logic        trip;
  logic        spike;

  // Sense ramp restarts at every turn-on; switch-off drops the sense level
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      on_count_reg <= 12'h000;
    end else if (i_gate) begin
      on_count_reg <= on_count_reg + 12'h001;
    end else begin
      on_count_reg <= 12'h000;
    end
  end

  assign trip  = i_gate && (i_trip_at != 12'h000) &&
                 (on_count_reg >= i_trip_at);
  // Turn-on spike reaches the sensed comparators, never the soft-start one
  assign spike = i_gate && (on_count_reg < {6'h00, i_spike_len});
  assign o_current_limit = (trip && i_sel == 2'h0) || spike;
  assign o_regulation    = (trip && i_sel == 2'h1) || spike;
  assign o_softstart     = trip && i_sel == 2'h2;
  assign o_burst_current = (trip && i_sel == 2'h3) || spike;
endmodule

// ---- test/softstart_pwm_blanking_control_test.sv ----
// Self-checking bench for the soft-start PWM and blanking core
`timescale 1ns/10ps
module softstart_pwm_blanking_control_test;
  import softstart_pwm_pkg::*;
  localparam int STEP  = 20;
  localparam int SSEND = 5000;
  localparam int BLANK = 50;
  localparam int LIMIT = 100000;

  logic                i_mclk = 1'b0;
  logic                i_reset_n = 1'b0;
  logic                supply = 1'b0;
  logic                short_w = 1'b0;
  logic                fb_low = 1'b0;
  logic                fb_high = 1'b0;
  logic                ext_level = 1'b0;
  logic [1:0]          sel = 2'h0;
  logic [11:0]         trip_at = 12'h000;
  logic                reg_c, ss_c, cl_c, bc_c;
  logic                o_gate, o_softstart_sink_en, o_burst_mode;
  logic                o_clamp_release, o_auto_restart, o_latched_off;
  logic                o_startup_cell_en;
  logic [SS_LVL_W-1:0] o_softstart_level;
  int                  fail_count = 0;
  int                  comparisons = 0;
  int                  cyc = 0;
  bit                  clamp_seen = 1'b0;
  int                  sels[4] = '{2, 0, 1, 3};
  int                  ats[4] = '{5, 10, 12, 100};

  always #4 i_mclk = ~i_mclk;

  softstart_pwm_blanking_control #(
    .SS_STEP_CYCLES (STEP),
    .SS_END_CYCLES  (SSEND),
    .BLANK_CYCLES   (BLANK),
    .JIT_STEP_CYCLES(4)
  ) i_dut (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(1'b1),
    .i_supply_good(supply), .i_regulation_cmp(reg_c),
    .i_softstart_cmp(ss_c), .i_current_limit_cmp(cl_c),
    .i_burst_current_cmp(bc_c), .i_short_winding_cmp(short_w),
    .i_feedback_low_cmp(fb_low), .i_feedback_high_cmp(fb_high),
    .i_extension_level_cmp(ext_level), .o_gate(o_gate),
    .o_softstart_level(o_softstart_level),
    .o_softstart_sink_en(o_softstart_sink_en),
    .o_burst_mode(o_burst_mode), .o_clamp_release(o_clamp_release),
    .o_auto_restart(o_auto_restart), .o_latched_off(o_latched_off),
    .o_startup_cell_en(o_startup_cell_en)
  );

  comparator_model i_far (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_gate(o_gate),
    .i_sel(sel), .i_trip_at(trip_at), .i_spike_len(6'h05),
    .o_current_limit(cl_c), .o_regulation(reg_c),
    .o_softstart(ss_c), .o_burst_current(bc_c)
  );

  task automatic results();
    if (fail_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Hang guard: sized well above the full sequence
  always @(posedge i_mclk) begin
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      fail_count = fail_count + 1;
      results();
    end
  end

  always @(negedge i_mclk) begin
    if (o_clamp_release === 1'b1) begin
      clamp_seen = 1'b1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return o_softstart_sink_en;
      1: return o_burst_mode;
      2: return o_clamp_release;
      3: return o_auto_restart;
      4: return o_latched_off;
      default: return o_gate;
    endcase
  endfunction

  task automatic wait_sig(input int k, input logic v, input int lim,
                          output int n);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(negedge i_mclk);
      n++;
    end
  endtask

  // High time of the next pulse and its rise-to-rise period
  task automatic pulse(output int hi, output int per);
    int n;
    wait_sig(5, 1'b0, 3000, n);
    wait_sig(5, 1'b1, 3000, n);
    hi = 0;
    while (o_gate === 1'b1 && hi < 3000) begin
      @(negedge i_mclk);
      hi++;
    end
    wait_sig(5, 1'b1, 3000, n);
    per = hi + n;
  endtask

  // Pulses without a trip stop only at the duty ceiling
  function automatic bit hi_ok(input int s, input int a, input int hi,
                               input bit in_burst);
    if (a == 0 || (s == 3 && !in_burst)) begin
      return hi >= 890 && hi <= 980;
    end
    if (s != 2 && a < LEB_CYC) begin
      return hi >= LEB_CYC - 1 && hi <= LEB_CYC + 6;
    end
    return hi >= a + 1 && hi <= a + 5;
  endfunction

  initial begin
    int hi, per, n, mn, mx, at, t0;
    void'($urandom(32'hd01a));
    repeat (12) @(negedge i_mclk);
    check({o_gate, o_burst_mode, o_auto_restart, o_latched_off}, 0);
    i_reset_n = 1'b1;
    repeat (20) @(negedge i_mclk);
    check({o_gate, o_softstart_sink_en, o_startup_cell_en}, 1);
    fb_high = 1'b1;
    supply = 1'b1;
    wait_sig(0, 1'b1, 10, n);
    t0 = cyc;
    check(o_softstart_level, 0);
    for (int k = 1; k <= SS_STEPS; k++) begin
      n = 0;
      while (o_softstart_level === SS_LVL_W'(k - 1) && n < 2 * STEP) begin
        @(negedge i_mclk);
        n++;
      end
      if (k > 1) begin
        check(n, STEP);
      end
      check(o_softstart_level, k);
    end
    repeat (STEP + 5) @(negedge i_mclk);
    check(o_softstart_level, SS_STEPS);
    repeat (2) begin
      pulse(hi, per);
      check(per, SW_PERIOD_CYC);
      check(4 * hi <= 3 * per, 1);
    end
    wait_sig(0, 1'b0, SSEND, n);
    fb_high = 1'b0;
    check(clamp_seen, 0);
    check(cyc - t0 >= SSEND - 3 && cyc - t0 <= SSEND + 3, 1);
    mn = 9999;
    mx = 0;
    repeat (6) begin
      pulse(hi, per);
      mn = per < mn ? per : mn;
      mx = per > mx ? per : mx;
      check(4 * hi <= 3 * per, 1);
      check(hi_ok(0, 0, hi, 0), 1);
    end
    check(mn >= 1200 && mx <= 1300, 1);
    check(mx > mn, 1);
    for (int k = 0; k < 10; k++) begin
      wait_sig(5, 1'b0, 3000, n);
      sel = k < 4 ? 2'(sels[k]) : 2'($urandom % 2);
      at = k < 4 ? ats[k] : 40 + $urandom % 400;
      trip_at = 12'(at);
      pulse(hi, per);
      check(hi_ok(sel, at, hi, 0), 1);
    end
    trip_at = 12'h000;
    fb_low = 1'b1;
    repeat (30) @(negedge i_mclk);
    fb_low = 1'b0;
    repeat (3) @(negedge i_mclk);
    check(o_burst_mode, 0);
    fb_low = 1'b1;
    wait_sig(1, 1'b1, BLANK + 20, n);
    check(n >= BLANK && n <= BLANK + 4, 1);
    check(o_startup_cell_en, 0);
    wait_sig(5, 1'b0, 3000, n);
    sel = 2'h3;
    trip_at = 12'd100;
    pulse(hi, per);
    check(hi_ok(3, 100, hi, 1), 1);
    trip_at = 12'h000;
    fb_low = 1'b0;
    fb_high = 1'b1;
    wait_sig(2, 1'b1, BLANK + 20, n);
    check(n >= BLANK && n <= BLANK + 4, 1);
    repeat (200) @(negedge i_mclk);
    check(o_auto_restart, 0);
    ext_level = 1'b1;
    repeat (RESTART_CYC - 10) @(negedge i_mclk);
    check(o_auto_restart, 0);
    wait_sig(3, 1'b1, 30, n);
    check(o_auto_restart, 1);
    @(negedge i_mclk);
    wait_sig(5, 1'b1, 1400, n);
    check(n, 1400);
    supply = 1'b0;
    fb_high = 1'b0;
    ext_level = 1'b0;
    repeat (5) @(negedge i_mclk);
    check({o_auto_restart, o_softstart_sink_en, o_gate}, 0);
    check(o_softstart_level, 0);
    check(o_startup_cell_en, 1);
    supply = 1'b1;
    wait_sig(0, 1'b1, 10, n);
    check(o_softstart_level, 0);
    short_w = 1'b1;
    repeat (20) @(negedge i_mclk);
    short_w = 1'b0;
    repeat (10) @(negedge i_mclk);
    check(o_latched_off, 0);
    short_w = 1'b1;
    wait_sig(4, 1'b1, 40, n);
    check(n >= SW_CYC && n <= SW_CYC + 4, 1);
    @(negedge i_mclk);
    wait_sig(5, 1'b1, 1400, n);
    check(n, 1400);
    results();
  end
endmodule
